// ==== src/dpch_pkg.sv ====
// package for the direct program control handshake: widths, timing, states
// assumes a single 50 MHz core clock on both ends
package dpch_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SKEW_NS       = 200;
   // least time rounds up to whole cycles
   localparam int SKEW_CYCLES   = (SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYCLES = 2;
   localparam int DATA_W        = 8;
   localparam int ADDR_W        = 8;
   localparam int MOD_W         = 4;
   localparam int FUNC_W        = 3;
   localparam int CNT_W         = 5;
   localparam logic [FUNC_W-1:0] FUNC_DEVICE_CLEAR = 3'h7;
   localparam logic [CNT_W-1:0]  CNT_ZERO          = 5'h00;
   // longest wait for select or its release before the sequence is abandoned
   localparam logic [CNT_W-1:0]  WAIT_CYCLES       = 5'h1f;
   localparam logic [15:0]       IRQ_RESET         = 16'h0000;

   typedef enum logic [1:0] {
      OP_OUTPUT    = 2'b00,
      OP_INPUT     = 2'b01,
      OP_INTERRUPT = 2'b10
   } dpch_op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SKEW   = 3'b001,
      ST_WAITSR = 3'b010,
      ST_STROBE = 3'b011,
      ST_DROP   = 3'b100,
      ST_WAITRL = 3'b101,
      ST_FINISH = 3'b110
   } dpch_state_t;

   // odd parity bit makes the nine bits carry odd weight
   function automatic logic oddParity(input logic [DATA_W-1:0] d);
      return ~(^d);
   endfunction
endpackage

// ==== src/dpch_if.sv ====
// interface carrying the attachment bus between adapter and user device
// every line is active low on the wire; names end in _n
interface dpch_if;
   logic [dpch_pkg::FUNC_W-1:0] func_n;
   logic [dpch_pkg::MOD_W-1:0]  mod_n;
   logic [dpch_pkg::ADDR_W-1:0] addr_n;
   logic [dpch_pkg::DATA_W-1:0] dataOut_n;
   logic                        dataOutPar_n;
   logic                        ioActive_n;
   logic                        intActive_n;
   logic                        strobe_n;
   logic                        selResp_n;
   logic [1:0]                  condCode_n;
   logic [dpch_pkg::DATA_W-1:0] dataIn_n;
   logic                        dataInPar_n;
   logic [15:0]                 intReq_n;

   modport adapter (output func_n, mod_n, addr_n, dataOut_n, dataOutPar_n, ioActive_n,
                    intActive_n, strobe_n,
                    input selResp_n, condCode_n, dataIn_n, dataInPar_n, intReq_n);
   modport device  (input func_n, mod_n, addr_n, dataOut_n, dataOutPar_n, ioActive_n,
                    intActive_n, strobe_n,
                    output selResp_n, condCode_n, dataIn_n, dataInPar_n, intReq_n);
endinterface

// ==== src/dpch_parity_chk.sv ====
// parity checker for one eight bit bus plus its parity line
// assumes true-polarity data and parity at its inputs
module dpch_parity_chk (
   input  wire logic [dpch_pkg::DATA_W-1:0] data,
   input  wire logic                        par,
   output logic                             parErr
);
   // odd parity over the nine bits
   assign parErr = (dpch_pkg::oddParity(data) != par);
endmodule // dpch_parity_chk

// ==== src/dpch_adapter.sv ====
// adapter end: runs output, input and interrupt service sequences on the bus
// assumes the device keeps its half of the handshake; one core clock
module dpch_adapter #(
   parameter bit HAS_PARITY_OPTION = 1'b0
) (
   input  wire logic                        core_clk,
   input  wire logic                        sys_rst,
   dpch_if.adapter                          bus,
   input  wire logic                        reqValid,
   output logic                             reqReady,
   input  wire dpch_pkg::dpch_op_t          reqOp,
   input  wire logic [dpch_pkg::FUNC_W-1:0] reqFunc,
   input  wire logic [dpch_pkg::MOD_W-1:0]  reqMod,
   input  wire logic [dpch_pkg::ADDR_W-1:0] reqAddr,
   input  wire logic [dpch_pkg::DATA_W-1:0] reqData,
   input  wire logic                        chanParErr,
   output logic                             doneValid,
   output logic                             doneStrobed,
   output logic                             doneParErr,
   output logic                             doneTimeout,
   output logic [1:0]                       doneCond,
   output logic [dpch_pkg::DATA_W-1:0]      doneData,
   output logic [15:0]                      intPending
);
   // fields first show one edge after capture, so the skew count must run
   // a full SKEW_CYCLES from there; one cycle short would break the 200 ns
   localparam logic [dpch_pkg::CNT_W-1:0] SKEW_LAST =
      dpch_pkg::CNT_W'(dpch_pkg::SKEW_CYCLES);
   localparam logic [dpch_pkg::CNT_W-1:0] STB_LAST =
      dpch_pkg::CNT_W'(dpch_pkg::STROBE_CYCLES - 1);
   localparam logic [dpch_pkg::CNT_W-1:0] WAIT_LAST = dpch_pkg::WAIT_CYCLES;

   dpch_pkg::dpch_state_t state;
   dpch_pkg::dpch_state_t next_state;
   dpch_pkg::dpch_op_t    op;
   logic [dpch_pkg::CNT_W-1:0] cnt;
   logic [dpch_pkg::FUNC_W-1:0] func;
   logic [dpch_pkg::MOD_W-1:0]  modi;
   logic [dpch_pkg::ADDR_W-1:0] addr;
   logic [dpch_pkg::DATA_W-1:0] dout;
   logic drive;
   logic drvData;
   logic inParErr;
   logic selAct;
   logic skipStrobe;
   logic timedOut;

   assign selAct   = ~bus.selResp_n;
   assign reqReady = (state == dpch_pkg::ST_IDLE);
   assign timedOut = (cnt == WAIT_LAST);

   dpch_parity_chk inChk (
      .data   (~bus.dataIn_n),
      .par    (~bus.dataInPar_n),
      .parErr (inParErr)
   );

   // strobe is withheld on an input parity fault and, without HAS_PARITY_OPTION, on a channel fault of an output other than device clear
   always_comb begin
      skipStrobe = 1'b0;
      if (op == dpch_pkg::OP_INPUT) begin
         skipStrobe = inParErr;
      end else if (op == dpch_pkg::OP_OUTPUT && !HAS_PARITY_OPTION) begin
         skipStrobe = chanParErr && (func != dpch_pkg::FUNC_DEVICE_CLEAR);
      end
   end

   // sequence state; a silent device is abandoned after a bounded wait
   always_comb begin
      next_state = state;
      case (state)
         dpch_pkg::ST_IDLE:   if (reqValid) next_state = dpch_pkg::ST_SKEW;
         dpch_pkg::ST_SKEW:   if (cnt == SKEW_LAST) next_state = dpch_pkg::ST_WAITSR;
         dpch_pkg::ST_WAITSR: begin
            if (selAct) next_state = skipStrobe ? dpch_pkg::ST_DROP : dpch_pkg::ST_STROBE;
            else if (timedOut) next_state = dpch_pkg::ST_DROP;
         end
         dpch_pkg::ST_STROBE: if (cnt == STB_LAST) next_state = dpch_pkg::ST_DROP;
         dpch_pkg::ST_DROP:   next_state = dpch_pkg::ST_WAITRL;
         dpch_pkg::ST_WAITRL: begin
            if (!selAct || timedOut) next_state = dpch_pkg::ST_FINISH;
         end
         dpch_pkg::ST_FINISH: next_state = dpch_pkg::ST_IDLE;
         default:             next_state = dpch_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) state <= dpch_pkg::ST_IDLE;
      else state <= next_state;
   end

   // one counter serves skew, strobe width and wait limits
   always_ff @(posedge core_clk) begin
      if (sys_rst || next_state != state) cnt <= dpch_pkg::CNT_ZERO;
      else if (!timedOut) cnt <= cnt + 5'h01;
   end

   // request capture; fields stay put until the sequence finishes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         op   <= dpch_pkg::OP_OUTPUT;
         func <= '0;
         modi <= '0;
         addr <= '0;
         dout <= '0;
      end else if (state == dpch_pkg::ST_IDLE && reqValid) begin
         op   <= reqOp;
         func <= reqFunc;
         modi <= reqMod;
         addr <= reqAddr;
         dout <= reqData;
      end
   end

   // lines are driven from skew start up to the final step
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         drive   <= 1'b0;
         drvData <= 1'b0;
      end else if (state == dpch_pkg::ST_IDLE && reqValid) begin
         drive   <= 1'b1;
         drvData <= (reqOp == dpch_pkg::OP_OUTPUT);
      end else if (state == dpch_pkg::ST_WAITRL && next_state == dpch_pkg::ST_FINISH) begin
         drive   <= 1'b0;
         drvData <= 1'b0;
      end
   end

   // active low wire levels; released lines float high
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bus.func_n       <= '1;
         bus.mod_n        <= '1;
         bus.addr_n       <= '1;
         bus.dataOut_n    <= '1;
         bus.dataOutPar_n <= 1'b1;
         bus.ioActive_n   <= 1'b1;
         bus.intActive_n  <= 1'b1;
         bus.strobe_n     <= 1'b1;
      end else begin
         // fields follow the captured copies only, so no stale address leaks
         // out on the capture edge of a back-to-back request
         bus.addr_n       <= ~(drive ? addr : '0);
         bus.func_n       <= ~(drive && op != dpch_pkg::OP_INTERRUPT ? func : '0);
         bus.mod_n        <= ~(drive && op != dpch_pkg::OP_INTERRUPT ? modi : '0);
         bus.dataOut_n    <= ~(drvData ? dout : '0);
         bus.dataOutPar_n <= ~(drvData && dpch_pkg::oddParity(dout));
         // tags stay one cycle past the strobe so they fall strictly after it
         bus.ioActive_n   <= ~((next_state == dpch_pkg::ST_WAITSR ||
                               next_state == dpch_pkg::ST_STROBE ||
                               next_state == dpch_pkg::ST_DROP) &&
                               op != dpch_pkg::OP_INTERRUPT);
         bus.intActive_n  <= ~((next_state == dpch_pkg::ST_WAITSR ||
                               next_state == dpch_pkg::ST_STROBE ||
                               next_state == dpch_pkg::ST_DROP) &&
                               op == dpch_pkg::OP_INTERRUPT);
         bus.strobe_n     <= ~(next_state == dpch_pkg::ST_STROBE);
      end
   end

   // device answers are sampled as the select arrives, before the strobe
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         doneCond    <= 2'h0;
         doneData    <= '0;
         doneParErr  <= 1'b0;
         doneStrobed <= 1'b0;
         doneTimeout <= 1'b0;
      end else if (state == dpch_pkg::ST_WAITSR) begin
         doneCond    <= ~bus.condCode_n;
         doneData    <= ~bus.dataIn_n;
         doneParErr  <= skipStrobe;
         doneStrobed <= selAct && !skipStrobe;
         doneTimeout <= !selAct && timedOut;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) doneValid <= 1'b0;
      else doneValid <= (state == dpch_pkg::ST_FINISH);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) intPending <= dpch_pkg::IRQ_RESET;
      else intPending <= ~bus.intReq_n;
   end
endmodule // dpch_adapter

// ==== src/dpch_device.sv ====
// user device end: answers select, condition code, data and interrupts
// assumes the adapter keeps skew and ordering; one core clock
module dpch_device #(
   parameter logic [dpch_pkg::ADDR_W-1:0] MY_ADDR = 8'h10
) (
   input  wire logic                        core_clk,
   input  wire logic                        sys_rst,
   dpch_if.device                           bus,
   input  wire logic [1:0]                  userCond,
   input  wire logic [dpch_pkg::DATA_W-1:0] userData,
   input  wire logic [15:0]                 userIrqSet,
   output logic                             wrValid,
   output logic [dpch_pkg::FUNC_W-1:0]      wrFunc,
   output logic [dpch_pkg::MOD_W-1:0]       wrMod,
   output logic [dpch_pkg::DATA_W-1:0]      wrData,
   output logic                             wrParErr,
   output logic                             intAck,
   output logic [15:0]                      irqPending
);
   logic match;
   logic anyActive;
   logic sel;
   logic strobePrev;
   logic strobeRise;
   logic outParErr;
   logic [1:0] condHold;
   logic [dpch_pkg::DATA_W-1:0] dataHold;

   assign match      = (~bus.addr_n == MY_ADDR);
   assign anyActive  = ~bus.ioActive_n | ~bus.intActive_n;
   assign strobeRise = ~bus.strobe_n & ~strobePrev;

   dpch_parity_chk outChk (
      .data   (~bus.dataOut_n),
      .par    (~bus.dataOutPar_n),
      .parErr (outParErr)
   );

   // select raised on match, held while a tag stays active
   always_ff @(posedge core_clk) begin
      if (sys_rst) sel <= 1'b0;
      else if (anyActive && (match || sel)) sel <= 1'b1;
      else sel <= 1'b0;
   end

   // answers frozen at select so they stay valid through the strobe
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         condHold <= 2'h0;
         dataHold <= '0;
      end else if (!sel) begin
         condHold <= userCond;
         dataHold <= userData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bus.selResp_n   <= 1'b1;
         bus.condCode_n  <= 2'h3;
         bus.dataIn_n    <= '1;
         bus.dataInPar_n <= 1'b1;
      end else begin
         bus.selResp_n   <= ~(anyActive && (match || sel));
         bus.condCode_n  <= ~(anyActive && (match || sel) ? (sel ? condHold : userCond)
                                                          : 2'h0);
         bus.dataIn_n    <= ~(anyActive && (match || sel) && bus.ioActive_n == 1'b0 &&
                              bus.func_n == '1 ? '0 :
                              anyActive && (match || sel) ? (sel ? dataHold : userData)
                                                          : '0);
         bus.dataInPar_n <= ~(anyActive && (match || sel) &&
                              dpch_pkg::oddParity(sel ? dataHold : userData));
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) strobePrev <= 1'b0;
      else strobePrev <= ~bus.strobe_n;
   end

   // output writes land on the strobe's leading edge
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wrValid  <= 1'b0;
         wrFunc   <= '0;
         wrMod    <= '0;
         wrData   <= '0;
         wrParErr <= 1'b0;
      end else begin
         wrValid <= strobeRise && sel && ~bus.ioActive_n;
         // held after the strobe, since the adapter releases the lines soon after
         if (strobeRise && sel && ~bus.ioActive_n) begin
            wrFunc   <= ~bus.func_n;
            wrMod    <= ~bus.mod_n;
            wrData   <= ~bus.dataOut_n;
            wrParErr <= outParErr;
         end
      end
   end

   // new requests win over the clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) irqPending <= dpch_pkg::IRQ_RESET;
      else if (strobeRise && sel && ~bus.intActive_n)
         irqPending <= userIrqSet;
      else irqPending <= irqPending | userIrqSet;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) intAck <= 1'b0;
      else intAck <= strobeRise && sel && ~bus.intActive_n;
   end

   assign bus.intReq_n = ~irqPending;
endmodule // dpch_device

// ==== bench/dpch_assertions.sv ====
// checker for the attachment bus between the adapter and device ends
// assumes one core clock, synchronous active-high reset, wire levels only
module dpch_assertions (
   input wire logic                        core_clk,
   input wire logic                        sys_rst,
   input wire logic [dpch_pkg::FUNC_W-1:0] func_n,
   input wire logic [dpch_pkg::ADDR_W-1:0] addr_n,
   input wire logic [dpch_pkg::DATA_W-1:0] dataOut_n,
   input wire logic                        ioActive_n,
   input wire logic                        intActive_n,
   input wire logic                        strobe_n,
   input wire logic                        selResp_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   logic [dpch_pkg::ADDR_W-1:0] lastAddr;
   logic [4:0]                  stableCnt;

   // edges the address has held still; saturates so long idles cannot wrap
   always_ff @(posedge core_clk) begin
      lastAddr <= addr_n;
      if (sys_rst || addr_n != lastAddr) begin
         stableCnt <= 5'h00;
      end else if (stableCnt != 5'h1f) begin
         stableCnt <= stableCnt + 5'h01;
      end
   end

   tag_skew_a: assert property (($fell(ioActive_n) || $fell(intActive_n))
      |-> stableCnt >= 5'(dpch_pkg::SKEW_CYCLES - 1))
      else $error("active tag raised before address settled");
   strobe_in_select_a: assert property (!strobe_n
      |-> !selResp_n && !(ioActive_n && intActive_n))
      else $error("strobe outside a selected transfer");
   strobe_width_a: assert property ($fell(strobe_n) |=> !strobe_n ##1 strobe_n)
      else $error("strobe not two cycles wide");
   select_under_tag_a: assert property ($fell(selResp_n)
      |-> !(ioActive_n && intActive_n))
      else $error("select raised without an active tag");
   select_held_a: assert property ($rose(selResp_n)
      |-> $past(ioActive_n) && $past(intActive_n))
      else $error("select dropped before tag fell");
   select_release_a: assert property (($rose(ioActive_n) || $rose(intActive_n))
      |-> ##[0:4] selResp_n)
      else $error("select not released after tag fell");
   lines_steady_a: assert property (!(ioActive_n && intActive_n)
      |-> $stable(addr_n) && $stable(func_n) && $stable(dataOut_n))
      else $error("fields moved under an active tag");
   release_order_a: assert property ((addr_n == '1 && $changed(addr_n))
      |-> selResp_n && $past(selResp_n) && ioActive_n && intActive_n)
      else $error("address released before select dropped");
   reset_idle_a: assert property ($fell(sys_rst)
      |-> ioActive_n && intActive_n && strobe_n && addr_n == '1)
      else $error("bus not negated after reset");

   cover property ($fell(strobe_n) && !ioActive_n);
   cover property ($fell(strobe_n) && !intActive_n);
   cover property ($rose(ioActive_n) && selResp_n && $past(selResp_n));
endmodule // dpch_assertions

// ==== bench/program_control_device_handshake_test.sv ====
// self-checking bench: adapter and device joined over the attachment bus
// assumes one 50 MHz clock for both ends; expectations come from the rules
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module program_control_device_handshake_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] DEV = 8'h10;

   logic               core_clk   = 1'b0;
   logic               sys_rst    = 1'b1;
   logic               reqValid   = 1'b0;
   dpch_pkg::dpch_op_t reqOp      = dpch_pkg::OP_OUTPUT;
   logic [2:0]         reqFunc    = 3'h0;
   logic [3:0]         reqMod     = 4'h0;
   logic [7:0]         reqAddr    = 8'h00;
   logic [7:0]         reqData    = 8'h00;
   logic               chanParErr = 1'b0;
   logic [1:0]         userCond   = 2'h0;
   logic [7:0]         userData   = 8'h00;
   logic [15:0]        userIrqSet = 16'h0000;
   logic               reqReady, doneValid, doneStrobed, doneParErr, doneTimeout;
   logic [1:0]         doneCond;
   logic [7:0]         doneData, wrData, busAddr, busData;
   logic [15:0]        intPending, irqPending;
   logic               wrValid, wrParErr, intAck, sawWr, sawAck, busPar;
   logic [2:0]         wrFunc, busFunc;
   logic [3:0]         wrMod;
   int                 miscompares = 0;
   int                 num_checks  = 0;

   dpch_if bus ();
   dpch_adapter u_dpch_adapter (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus.adapter),
      .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqFunc(reqFunc),
      .reqMod(reqMod), .reqAddr(reqAddr), .reqData(reqData), .chanParErr(chanParErr),
      .doneValid(doneValid), .doneStrobed(doneStrobed), .doneParErr(doneParErr),
      .doneTimeout(doneTimeout), .doneCond(doneCond), .doneData(doneData),
      .intPending(intPending));
   dpch_device #(.MY_ADDR(DEV)) u_dpch_device (.core_clk(core_clk), .sys_rst(sys_rst),
      .bus(bus.device), .userCond(userCond), .userData(userData), .userIrqSet(userIrqSet),
      .wrValid(wrValid), .wrFunc(wrFunc), .wrMod(wrMod), .wrData(wrData),
      .wrParErr(wrParErr), .intAck(intAck), .irqPending(irqPending));
   dpch_assertions u_dpch_assertions (.core_clk(core_clk), .sys_rst(sys_rst),
      .func_n(bus.func_n), .addr_n(bus.addr_n), .dataOut_n(bus.dataOut_n),
      .ioActive_n(bus.ioActive_n), .intActive_n(bus.intActive_n),
      .strobe_n(bus.strobe_n), .selResp_n(bus.selResp_n));

   // free-running core clock, 20 ns period
   always #10 core_clk = ~core_clk;

   // prints the counts and the verdict, then ends the run
   task automatic finish_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one request, then a bounded wait for completion while the wire is sampled
   task automatic run_op(input dpch_pkg::dpch_op_t op, input logic [2:0] f,
                         input logic [7:0] a, input logic [7:0] d, input logic perr);
      int n;
      @(posedge core_clk);
      reqValid <= 1'b1;
      reqOp <= op;
      reqFunc <= f;
      reqMod <= 4'h9;
      reqAddr <= a;
      reqData <= d;
      chanParErr <= perr;
      @(posedge core_clk);
      reqValid <= 1'b0;
      sawWr = 1'b0;
      sawAck = 1'b0;
      for (n = 0; n < 300; n++) begin
         @(posedge core_clk);
         #1;
         if (wrValid === 1'b1) sawWr = 1'b1;
         if (intAck === 1'b1) sawAck = 1'b1;
         // capture fields while a tag is low, the window where they must be valid
         if (bus.ioActive_n === 1'b0 || bus.intActive_n === 1'b0) begin
            busAddr = bus.addr_n;
            busData = bus.dataOut_n;
            busFunc = bus.func_n;
            busPar = bus.dataOutPar_n;
         end
         if (doneValid === 1'b1) break;
      end
      if (n == 300) begin
         miscompares++;
         finish_test();
      end
      // hand back on an edge so callers drive inputs there by non-blocking assignment
      @(posedge core_clk);
   endtask

   // selected output transfer: wire levels inverted, odd parity, data delivered
   task automatic check_out(input logic [2:0] f, input logic [7:0] d);
      run_op(dpch_pkg::OP_OUTPUT, f, DEV, d, 1'b0);
      `CHK(doneStrobed, 1'b1)
      `CHK(sawWr, 1'b1)
      `CHK(wrData, d)
      `CHK(wrFunc, f)
      `CHK(wrMod, 4'h9)
      `CHK(wrParErr, 1'b0)
      `CHK(busData, ~d)
      `CHK(busPar, ^d)
      `CHK(busFunc, ~f)
      `CHK(busAddr, ~DEV)
      `CHK(doneCond, userCond)
   endtask

   logic [7:0] outData [4] = '{8'h01, 8'h80, 8'h5a, 8'hfe};

   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      // back-to-back outputs cover both end bits and both parity cases
      for (int i = 0; i < 4; i++) begin
         userCond <= 2'(i);
         check_out(3'(i + 1), outData[i]);
      end
      userData <= 8'hc3;
      userCond <= 2'h2;
      run_op(dpch_pkg::OP_INPUT, 3'h3, DEV, 8'h00, 1'b0);
      `CHK(doneData, 8'hc3)
      `CHK(doneCond, 2'h2)
      `CHK(doneStrobed, 1'b1)
      `CHK(doneParErr, 1'b0)
      `CHK(busData, 8'hff)
      `CHK(wrData, 8'h00)
      // raise one interrupt line, then serve it
      userIrqSet <= 16'h0008;
      @(posedge core_clk);
      userIrqSet <= 16'h0000;
      for (int n = 0; n < 20 && intPending !== 16'h0008; n++) @(posedge core_clk);
      `CHK(intPending, 16'h0008)
      run_op(dpch_pkg::OP_INTERRUPT, 3'h0, DEV, 8'h00, 1'b0);
      `CHK(sawAck, 1'b1)
      `CHK(irqPending, 16'h0000)
      `CHK(intPending, 16'h0000)
      `CHK(doneData, 8'hc3)
      `CHK(busAddr, ~DEV)
      // function zero keeps the device off the inbound bus: parity fails, no strobe
      userData <= 8'h01;
      run_op(dpch_pkg::OP_INPUT, 3'h0, DEV, 8'h00, 1'b0);
      `CHK(doneParErr, 1'b1)
      `CHK(doneStrobed, 1'b0)
      // nobody answers: the wait limit ends the transfer without strobe
      run_op(dpch_pkg::OP_OUTPUT, 3'h2, 8'h22, 8'h33, 1'b0);
      `CHK(doneTimeout, 1'b1)
      `CHK(doneStrobed, 1'b0)
      `CHK(sawWr, 1'b0)
      // channel parity fault: strobe withheld except for device clear
      run_op(dpch_pkg::OP_OUTPUT, 3'h2, DEV, 8'h44, 1'b1);
      `CHK(doneStrobed, 1'b0)
      `CHK(sawWr, 1'b0)
      run_op(dpch_pkg::OP_OUTPUT, dpch_pkg::FUNC_DEVICE_CLEAR, DEV, 8'h44, 1'b1);
      `CHK(doneStrobed, 1'b1)
      `CHK(sawWr, 1'b1)
      // second reset mid-run, then the link must work again
      @(posedge core_clk);
      chanParErr <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(bus.addr_n, 8'hff)
      `CHK(bus.ioActive_n, 1'b1)
      `CHK(reqReady, 1'b1)
      @(posedge core_clk);
      sys_rst <= 1'b0;
      check_out(3'h4, 8'hff);
      finish_test();
   end
endmodule // program_control_device_handshake_test
